// ===== pkg/psmc_params.svh
`ifndef PSMC_PARAMS_SVH
`define PSMC_PARAMS_SVH

// power-save operand codes
`define PSMC_OP_SLEEP 1'h0
`define PSMC_OP_IDLE 1'h1
// oscillator control field position and reset
`define PSMC_NOSC_MSB 10
`define PSMC_NOSC_LSB 8
`define PSMC_OSC_RESET 3'h0
// clock settle time after wake from sleep, ns, and cycles at 20 ns
`define PSMC_SETTLE_NS 400
`define PSMC_CLK_NS 20
`define PSMC_SETTLE_CYC ((`PSMC_SETTLE_NS + `PSMC_CLK_NS - 1) / `PSMC_CLK_NS)
// doze divider width and peripheral count
`define PSMC_DOZE_W 3
`define PSMC_NPER 8

`endif

// ===== pkg/psmc_pkg.sv
`default_nettype none
package psmc_pkg;

    typedef enum logic [1:0] {
        PSMC_RUN = 2'b00,
        PSMC_SLEEP = 2'b01,
        PSMC_IDLE = 2'b10,
        PSMC_SETTLE = 2'b11
    } psmc_state_e;

    typedef struct packed {
        logic irq;
        logic wdt_timeout;
    } psmc_wake_s;

    typedef struct packed {
        logic valid;
        logic operand;
    } psmc_req_s;

endpackage
`default_nettype wire

// ===== rtl/psmc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "psmc_params.svh"

module psmc_ctrl
    import psmc_pkg::*;
(
    // system
    input wire logic clock,
    input wire logic rstn,
    // core request
    input wire psmc_req_s power_save_instruction,
    // wake sources
    input wire psmc_wake_s wake,
    // oscillator control
    input wire logic osc_write,
    input wire logic [`PSMC_NOSC_MSB:`PSMC_NOSC_LSB] new_oscillator_select,
    input wire logic clock_config_locked,
    output logic [2:0] osc_select,
    // doze and peripheral gating
    input wire logic doze_enable,
    input wire logic [`PSMC_DOZE_W-1:0] doze_ratio,
    input wire logic [`PSMC_NPER-1:0] periph_disable,
    // outputs
    output logic cpu_clk_en,
    output logic [`PSMC_NPER-1:0] periph_clk_en,
    output logic in_sleep,
    output logic in_idle
);

    // ----------------------------------------
    // power state
    // ----------------------------------------
    psmc_state_e state_q, state_d;
    logic [7:0] settle_q, settle_d;
    logic wake_evt;

    assign wake_evt = wake.irq | wake.wdt_timeout;

    always_comb begin
        state_d = state_q;
        settle_d = settle_q;
        case (state_q)
            PSMC_RUN: begin
                if (power_save_instruction.valid) begin
                    if (power_save_instruction.operand == `PSMC_OP_SLEEP) begin
                        state_d = PSMC_SLEEP;
                    end else begin
                        state_d = PSMC_IDLE;
                    end
                end
            end
            PSMC_SLEEP: begin
                if (wake_evt) begin
                    state_d = PSMC_SETTLE;
                    settle_d = 8'(`PSMC_SETTLE_CYC);
                end
            end
            PSMC_IDLE: begin
                if (wake_evt) begin
                    state_d = PSMC_RUN;
                end
            end
            PSMC_SETTLE: begin
                // oscillator restarts; hold fetch until it settles
                if (settle_q <= 8'h01) begin
                    state_d = PSMC_RUN;
                    settle_d = 8'h00;
                end else begin
                    settle_d = settle_q - 8'h01;
                end
            end
            default: begin
                state_d = PSMC_RUN;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= PSMC_RUN;
            settle_q <= 8'h00;
        end else begin
            state_q <= state_d;
            settle_q <= settle_d;
        end
    end

    // ----------------------------------------
    // oscillator select
    // ----------------------------------------
    logic [2:0] osc_q, osc_d;

    always_comb begin
        osc_d = osc_q;
        if (osc_write && !clock_config_locked) begin
            osc_d = new_oscillator_select;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            osc_q <= `PSMC_OSC_RESET;
        end else begin
            osc_q <= osc_d;
        end
    end

    assign osc_select = osc_q;

    // ----------------------------------------
    // doze divider
    // ----------------------------------------
    logic [6:0] doze_cnt_q, doze_cnt_d;
    logic [6:0] doze_max;
    logic doze_tick;

    // ratio n divides the core clock by 2^n
    assign doze_max = 7'((8'h01 << doze_ratio) - 8'h01);
    assign doze_tick = !doze_enable || (doze_cnt_q == 7'h00);

    always_comb begin
        doze_cnt_d = doze_cnt_q;
        if (!doze_enable || doze_cnt_q >= doze_max) begin
            doze_cnt_d = 7'h00;
        end else begin
            doze_cnt_d = doze_cnt_q + 7'h01;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            doze_cnt_q <= 7'h00;
        end else begin
            doze_cnt_q <= doze_cnt_d;
        end
    end

    // ----------------------------------------
    // registered enables
    // ----------------------------------------
    // enables are flops so downstream gating latches see clean levels
    logic cpu_en_q, cpu_en_d;
    logic [`PSMC_NPER-1:0] per_en_q, per_en_d;

    always_comb begin
        cpu_en_d = (state_d == PSMC_RUN) && doze_tick;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `PSMC_NPER; gi = gi + 1) begin : g_per
            always_comb begin
                per_en_d[gi] = (state_d != PSMC_SLEEP) && (state_d != PSMC_SETTLE)
                    && !periph_disable[gi];
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cpu_en_q <= 1'b0;
            per_en_q <= '0;
        end else begin
            cpu_en_q <= cpu_en_d;
            per_en_q <= per_en_d;
        end
    end

    assign cpu_clk_en = cpu_en_q;
    assign periph_clk_en = per_en_q;
    assign in_sleep = (state_q == PSMC_SLEEP);
    assign in_idle = (state_q == PSMC_IDLE);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_sleep_entry: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == PSMC_RUN && power_save_instruction.valid
         && power_save_instruction.operand == `PSMC_OP_SLEEP)
        |=> in_sleep ##1 (cpu_clk_en == 1'b0 && periph_clk_en == '0))
        else $error("sleep entry did not stop clocks");

    a_idle_periph: assert property (@(posedge clock) disable iff (!rstn)
        (in_idle && $past(in_idle)) |-> (!cpu_clk_en && periph_clk_en == ~$past(periph_disable)))
        else $error("idle clocking wrong");

    a_sleep_hold: assert property (@(posedge clock) disable iff (!rstn)
        (in_sleep && !wake_evt) |=> in_sleep)
        else $error("sleep left without wake");

    a_idle_wake: assert property (@(posedge clock) disable iff (!rstn)
        (in_idle && wake_evt) |=> (state_q == PSMC_RUN) ##1 (cpu_clk_en || doze_enable))
        else $error("idle wake failed");

    // settle cycles counted apart from the design counter, so a wrong reload shows up
    logic [7:0] settle_run_q, settle_run_d;

    always_comb begin
        settle_run_d = 8'h00;
        if (state_q == PSMC_SETTLE) begin
            settle_run_d = settle_run_q + 8'h01;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            settle_run_q <= 8'h00;
        end else begin
            settle_run_q <= settle_run_d;
        end
    end

    a_settle_time: assert property (@(posedge clock) disable iff (!rstn)
        (in_sleep && wake_evt) |=> (state_q == PSMC_SETTLE && !cpu_clk_en && periph_clk_en == '0))
        else $error("sleep wake did not start settling");

    a_settle_hold: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == PSMC_SETTLE && settle_run_q < 8'(`PSMC_SETTLE_CYC - 1))
        |=> (state_q == PSMC_SETTLE && !cpu_clk_en))
        else $error("settle ended early");

    a_settle_exit: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == PSMC_SETTLE && settle_run_q == 8'(`PSMC_SETTLE_CYC - 1))
        |=> (state_q == PSMC_RUN && (cpu_clk_en || doze_enable)))
        else $error("settle did not end on time");

    a_osc_locked: assert property (@(posedge clock) disable iff (!rstn)
        clock_config_locked |=> $stable(osc_select))
        else $error("oscillator changed while locked");

    a_osc_write: assert property (@(posedge clock) disable iff (!rstn)
        (osc_write && !clock_config_locked) |=> osc_select == $past(new_oscillator_select))
        else $error("oscillator write lost");

    a_doze_gap: assert property (@(posedge clock) disable iff (!rstn)
        (doze_enable && $past(doze_enable) && doze_ratio == 3'h1 && $stable(doze_ratio)
         && state_q == PSMC_RUN && cpu_clk_en)
        |=> (state_q != PSMC_RUN || !cpu_clk_en))
        else $error("doze divider wrong");

    c_sleep_wake: cover property (@(posedge clock) disable iff (!rstn) in_sleep ##1 state_q == PSMC_SETTLE);
    c_idle_wake: cover property (@(posedge clock) disable iff (!rstn) in_idle ##1 state_q == PSMC_RUN);
    c_doze: cover property (@(posedge clock) disable iff (!rstn) doze_enable && !cpu_clk_en && state_q == PSMC_RUN);

endmodule

`default_nettype wire

// ===== test/psmc_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------
// core side: issues the power-save instruction
// ---------------------------------------------
module psmc_core_model
    import psmc_pkg::*;
(
    // system
    input wire logic clock,
    // command from bench
    input wire logic go,
    input wire logic op,
    // clock enable from the block
    input wire logic cpu_clk_en,
    // request out
    output var psmc_req_s req
);
    // a halted core cannot execute anything, so no request while its clock is off
    always_ff @(posedge clock) begin
        req <= '{valid: go && cpu_clk_en, operand: op};
    end
endmodule
`default_nettype wire

// ===== test/power_saving_mode_control_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "psmc_params.svh"
module power_saving_mode_control_test;
    import psmc_pkg::*;
    typedef struct {logic wr; logic lk; logic [2:0] v; logic [2:0] exp;} psmc_row_s;
    logic clock = 1'h0, rstn = 1'h0, go = 1'h0, op = 1'h0, osc_write = 1'h0, locked = 1'h0, doze_enable = 1'h0;
    logic [2:0] nosc = 3'h0, doze_ratio = 3'h0, osc_select;
    logic [7:0] periph_disable = 8'h00, periph_clk_en;
    logic cpu_clk_en, in_sleep, in_idle;
    psmc_wake_s wake = '0;
    psmc_req_s req;
    int failures = 0, total_checks = 0, cycles = 0, n;
    psmc_row_s rows [5] = '{'{1, 0, 3'h5, 3'h5}, '{1, 1, 3'h2, 3'h5}, '{0, 0, 3'h3, 3'h5},
                            '{1, 0, 3'h0, 3'h0}, '{1, 0, 3'h7, 3'h7}};
    psmc_core_model core (.clock(clock), .go(go), .op(op), .cpu_clk_en(cpu_clk_en), .req(req));
    psmc_ctrl dut (.clock(clock), .rstn(rstn), .power_save_instruction(req), .wake(wake),
        .osc_write(osc_write), .new_oscillator_select(nosc), .clock_config_locked(locked),
        .osc_select(osc_select), .doze_enable(doze_enable), .doze_ratio(doze_ratio),
        .periph_disable(periph_disable), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .in_sleep(in_sleep), .in_idle(in_idle));
    always #10 clock = ~clock;
    task end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // a hang costs one mismatch, then the usual verdict
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures = failures + 1;
            $display("Error %0t timeout", $time);
            end_sim();
        end
    end
    task check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            failures++;
            $display("Error %0t %s", $time, msg);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask
    task inst(input logic o);
        @(posedge clock);
        go <= 1'h1;
        op <= o;
        @(posedge clock);
        go <= 1'h0;
        tick(4);
    endtask
    task pulse_wake(input logic wdt);
        @(posedge clock);
        wake <= wdt ? 2'h1 : 2'h2;
        @(posedge clock);
        wake <= 2'h0;
    endtask
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        tick(2);
        check(cpu_clk_en === 1'h0 && periph_clk_en === 8'h00 && osc_select === 3'h0, "reset outputs");
        @(posedge clock);
        rstn <= 1'h1;
        foreach (rows[i]) begin
            @(posedge clock);
            osc_write <= rows[i].wr;
            locked <= rows[i].lk;
            nosc <= rows[i].v;
            @(posedge clock);
            osc_write <= 1'h0;
            tick(1);
            check(osc_select === rows[i].exp, "oscillator select");
        end
        inst(`PSMC_OP_SLEEP);
        check(in_sleep === 1'h1 && cpu_clk_en === 1'h0 && periph_clk_en === 8'h00, "sleep entry");
        periph_disable <= 8'h0f;
        tick(30);
        check(in_sleep === 1'h1, "sleep left without wake");
        pulse_wake(1'h0);
        n = 0;
        while (cpu_clk_en !== 1'h1 && n < 40) begin
            tick(1);
            n++;
        end
        check(n >= `PSMC_SETTLE_CYC && n < 40 && in_sleep === 1'h0, "settle after sleep");
        check(periph_clk_en === 8'hf0, "peripheral gating");
        inst(`PSMC_OP_IDLE);
        check(in_idle === 1'h1 && cpu_clk_en === 1'h0 && periph_clk_en === 8'hf0, "idle entry");
        pulse_wake(1'h1);
        tick(3);
        check(in_idle === 1'h0 && cpu_clk_en === 1'h1, "watchdog wake from idle");
        inst(`PSMC_OP_SLEEP);
        rstn <= 1'h0;
        tick(2);
        check(in_sleep === 1'h0 && osc_select === 3'h0, "reset during sleep");
        rstn <= 1'h1;
        tick(2);
        check(cpu_clk_en === 1'h1 && periph_clk_en === ~periph_disable, "run after reset");
        for (int r = 0; r < 3; r++) begin
            doze_ratio <= r[2:0];
            doze_enable <= 1'h1;
            tick(8);
            n = 0;
            repeat (8) begin
                n += (cpu_clk_en === 1'h1);
                tick(1);
            end
            check(n == (8 >> r), "doze rate");
        end
        end_sim();
    end
endmodule
`default_nettype wire
